// *** rtl/prs_paged_decoder.sv ***
// paged special-register decoder with a three-level page stack
// assumes the core gives one access per valid cycle and pulses
// interrupt entry and return for one core_clk cycle each
// assumes everything arrives on core_clk, so no input is
// synchronised here; a source in another domain must be
// brought over before it reaches these ports
`timescale 1ns/1ps
module prs_paged_decoder
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              reset,
   // direct access from the core
   input  wire prs_pkg::prs_acc_s acc_in,
   // interrupt entry and return from the core
   input  wire logic              irq_enter,
   input  wire logic [7:0]        irq_page,
   input  wire logic              return_from_interrupt,
   // access steered to paged registers
   output logic                   sfr_out_valid,
   output prs_pkg::prs_sfr_s      sfr_out,
   // access passed on to ram
   output logic                   ram_valid,
   output logic [7:0]             ram_addr,
   // read answer for the stack and control registers
   output logic                   rd_valid,
   output logic [7:0]             rd_data,
   // refused accesses
   output logic                   bit_reject,
   output logic                   page_miss,
   // current state
   output logic [7:0]             page_select,
   output logic [7:0]             page_stack_middle,
   output logic [7:0]             page_stack_bottom,
   output logic                   auto_paging_enable
);

   // ==========================================================
   // helper functions
   // each decode is called from a single process only; the verdicts
   // are shared with the other process through the signals below

   // true for addresses in the paged register range
   function automatic logic in_sfr_range(input logic [7:0] a);
      in_sfr_range = (a >= prs_pkg::SFR_BASE);
   endfunction

   // true where single-bit access is allowed
   function automatic logic bit_ok(input logic [7:0] a);
      bit_ok = (a[3:0] == prs_pkg::BIT_NIB_A) ||
               (a[3:0] == prs_pkg::BIT_NIB_B);
   endfunction

   // true for pages that hold registers
   // pages 4 to e and those above f select no paged register
   function automatic logic page_impl(input logic [7:0] p);
      page_impl = (p <= prs_pkg::PAGE_3) || (p == prs_pkg::PAGE_F);
   endfunction

   // true for the registers this block holds itself
   // these four answer on every page, whatever is selected
   function automatic logic is_local(input logic [7:0] a);
      is_local = (a == prs_pkg::ADDR_PAGE_SEL)  ||
                 (a == prs_pkg::ADDR_STACK_MID) ||
                 (a == prs_pkg::ADDR_STACK_BOT) ||
                 (a == prs_pkg::ADDR_PAGE_CTRL);
   endfunction

   // ==========================================================
   // access classification, shared by both groups of state

   logic acc_sfr;     // direct access in the paged range
   logic acc_badbit;  // bit access at a byte-only address
   logic acc_local;   // hits a register held here
   logic acc_ok;      // legal access to the paged range

   // decode the incoming access
   // computed once so both groups of state see one verdict
   always_comb
   begin
      acc_sfr    = acc_in.valid && acc_in.direct &&
                   in_sfr_range(acc_in.addr);
      acc_badbit = acc_sfr && acc_in.bit_op &&
                   !bit_ok(acc_in.addr);
      // the local registers are byte-only, so a bit access to
      // them is refused by the nibble test above as well
      acc_local  = is_local(acc_in.addr);
      acc_ok     = acc_sfr && !acc_badbit;
   end

   // ==========================================================
   // page stack and control bit

   // page stack: top is the live page, mid and bot hold saved ones
   prs_pkg::prs_stack_s stk_r;
   prs_pkg::prs_stack_s stk_nxt;
   logic                auto_en_r; // automatic paging enable
   logic                auto_en_nxt;
   logic [7:0]          sw_val;    // value software writes

   // next stack state; interrupt events outrank software writes
   // because a write racing an entry would lose the saved page
   always_comb
   begin
      stk_nxt     = stk_r;
      auto_en_nxt = auto_en_r;
      sw_val      = acc_in.wdata;
      if (irq_enter && auto_en_r)
      begin
         // push: every level moves down, source page on top
         // nesting deeper than two drops the oldest saved page
         stk_nxt.bot = stk_r.mid;
         stk_nxt.mid = stk_r.top;
         stk_nxt.top = irq_page;
      end
      else if (return_from_interrupt && auto_en_r)
      begin
         // pop: bottom empties to page zero
         // a pop with nothing saved leaves page zero on top
         stk_nxt.top = stk_r.mid;
         stk_nxt.mid = stk_r.bot;
         stk_nxt.bot = prs_pkg::EMPTY_PAGE;
      end
      else if (acc_ok && acc_in.write && acc_local)
      begin
         // plain stores, the stack never moves here
         case (acc_in.addr)
            prs_pkg::ADDR_PAGE_SEL:
            begin
               stk_nxt.top = sw_val;
            end
            prs_pkg::ADDR_STACK_MID:
            begin
               stk_nxt.mid = sw_val;
            end
            prs_pkg::ADDR_STACK_BOT:
            begin
               stk_nxt.bot = sw_val;
            end
            prs_pkg::ADDR_PAGE_CTRL:
            begin
               auto_en_nxt = sw_val[prs_pkg::POS_AUTO_EN];
            end
            // unreachable: acc_local admits only the four above
            default:
            begin
               stk_nxt = stk_r;
            end
         endcase
      end
   end

   // synchronous reset keeps every flop on the one clock path
   // register the stack; the two interrupt events and software stores change it
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         stk_r.top <= prs_pkg::RST_PAGE;
         stk_r.mid <= prs_pkg::RST_STACK;
         stk_r.bot <= prs_pkg::RST_STACK;
         auto_en_r <= prs_pkg::RST_AUTO_EN;
      end
      else
      begin
         stk_r     <= stk_nxt;
         auto_en_r <= auto_en_nxt;
      end
   end

   // ==========================================================
   // access steering, one cycle behind the request
   // one cycle of latency buys registered outputs everywhere;
   // the price is that a page write only steers accesses
   // from the following cycle on

   logic              sfr_v_r;     // paged access out
   logic              sfr_v_nxt;
   prs_pkg::prs_sfr_s sfr_r;
   prs_pkg::prs_sfr_s sfr_nxt;
   logic              ram_v_r;     // ram access out
   logic              ram_v_nxt;
   logic [7:0]        ram_a_r;
   logic [7:0]        ram_a_nxt;
   logic              rd_v_r;      // local read answer
   logic              rd_v_nxt;
   logic [7:0]        rd_d_r;
   logic [7:0]        rd_d_nxt;
   logic              badbit_r;    // refused bit access
   logic              badbit_nxt;
   logic              miss_r;      // access to an empty page
   logic              miss_nxt;

   // steer the access; local registers answer on every page so
   // software can always get back to a known page
   always_comb
   begin
      sfr_v_nxt       = 1'b0;
      sfr_nxt         = sfr_r;
      ram_v_nxt       = 1'b0;
      ram_a_nxt       = ram_a_r;
      rd_v_nxt        = 1'b0;
      rd_d_nxt        = rd_d_r;
      badbit_nxt      = acc_badbit;
      miss_nxt        = 1'b0;
      if (acc_in.valid && !acc_sfr)
      begin
         // indirect or low-range access goes to ram
         // the address is held between pulses for a slow reader
         ram_v_nxt = 1'b1;
         ram_a_nxt = acc_in.addr;
      end
      else if (acc_ok && acc_local)
      begin
         // reads of stack and control show current state
         // a local write gives no pulse; the value shows next cycle
         rd_v_nxt = !acc_in.write;
         case (acc_in.addr)
            prs_pkg::ADDR_PAGE_SEL:
            begin
               rd_d_nxt = stk_r.top;
            end
            prs_pkg::ADDR_STACK_MID:
            begin
               rd_d_nxt = stk_r.mid;
            end
            prs_pkg::ADDR_STACK_BOT:
            begin
               rd_d_nxt = stk_r.bot;
            end
            default:
            begin
               rd_d_nxt = {7'h00, auto_en_r};
            end
         endcase
      end
      else if (acc_ok && page_impl(stk_r.top))
      begin
         // the current page picks which register answers
         // bit index passes through; the register file applies it
         sfr_v_nxt       = 1'b1;
         sfr_nxt.valid   = 1'b1;
         sfr_nxt.write   = acc_in.write;
         sfr_nxt.bit_op  = acc_in.bit_op;
         sfr_nxt.bit_idx = acc_in.bit_idx;
         sfr_nxt.page    = stk_r.top;
         sfr_nxt.addr    = acc_in.addr;
         sfr_nxt.wdata   = acc_in.wdata;
      end
      else if (acc_ok)
      begin
         // empty page: nothing answers, flagged only
         // nothing is forwarded, so no register is hit by mistake
         miss_nxt = 1'b1;
      end
   end

   // register the steering outputs
   // every steering output port below is one of these flops; the state ports come from the stack flops
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         sfr_v_r  <= 1'b0;
         sfr_r    <= '0;
         ram_v_r  <= 1'b0;
         ram_a_r  <= 8'h00;
         rd_v_r   <= 1'b0;
         rd_d_r   <= 8'h00;
         badbit_r <= 1'b0;
         miss_r   <= 1'b0;
      end
      else
      begin
         sfr_v_r  <= sfr_v_nxt;
         sfr_r    <= sfr_nxt;
         ram_v_r  <= ram_v_nxt;
         ram_a_r  <= ram_a_nxt;
         rd_v_r   <= rd_v_nxt;
         rd_d_r   <= rd_d_nxt;
         badbit_r <= badbit_nxt;
         miss_r   <= miss_nxt;
      end
   end

   // ==========================================================
   // outputs, all straight from flip-flops
   // note: unoccupied addresses on a real page are passed on
   // untouched; what answers there is left to the register file
   // the three stack levels are shown as levels so the core can
   // save and restore them around nested handlers

   assign sfr_out_valid      = sfr_v_r;
   assign sfr_out            = sfr_r;
   assign ram_valid          = ram_v_r;
   assign ram_addr           = ram_a_r;
   assign rd_valid           = rd_v_r;
   assign rd_data            = rd_d_r;
   assign bit_reject         = badbit_r;
   assign page_miss          = miss_r;
   assign page_select        = stk_r.top;
   assign page_stack_middle  = stk_r.mid;
   assign page_stack_bottom  = stk_r.bot;
   assign auto_paging_enable = auto_en_r;

endmodule

// *** shared/prs_pkg.sv ***
// package for the paged special-register decoder
// assumes one core clock and a core that flags direct accesses
package prs_pkg;

   // ==========================================================
   // address space
   localparam logic [7:0] SFR_BASE       = 8'h80; // first paged address
   localparam logic [3:0] BIT_NIB_A      = 4'h0;  // bit-addressable nibble
   localparam logic [3:0] BIT_NIB_B      = 4'h8;  // bit-addressable nibble

   // ==========================================================
   // stack and control register offsets, seen on every page
   localparam logic [7:0] ADDR_PAGE_SEL  = 8'h84;
   localparam logic [7:0] ADDR_STACK_MID = 8'h85;
   localparam logic [7:0] ADDR_STACK_BOT = 8'h86;
   localparam logic [7:0] ADDR_PAGE_CTRL = 8'h8f;
   localparam int         POS_AUTO_EN    = 0;     // enable bit position

   // ==========================================================
   // implemented pages
   localparam logic [7:0] PAGE_0         = 8'h00;
   localparam logic [7:0] PAGE_3         = 8'h03;
   localparam logic [7:0] PAGE_F         = 8'h0f;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_PAGE       = 8'h00;
   localparam logic [7:0] RST_STACK      = 8'h00;
   localparam logic       RST_AUTO_EN    = 1'b1;
   localparam logic [7:0] EMPTY_PAGE     = 8'h00;

   // one access from the core, direct or indirect
   typedef struct packed {
      logic       valid;
      logic       direct;  // direct addressing mode
      logic       write;
      logic       bit_op;  // single-bit access
      logic [2:0] bit_idx;
      logic [7:0] addr;
      logic [7:0] wdata;
   } prs_acc_s;

   // access steered to the paged register file
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       bit_op;
      logic [2:0] bit_idx;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } prs_sfr_s;

   // state of the page stack
   typedef struct packed {
      logic [7:0] top;
      logic [7:0] mid;
      logic [7:0] bot;
   } prs_stack_s;

endpackage

// *** testbench/prs_checker_properties.sv ***
// checker for the paged register decoder ports
// assumes it is bound to prs_paged_decoder
`timescale 1ns/1ps
module prs_checker
(
   // clock, reset and core side
   input wire logic              core_clk,
   input wire logic              reset,
   input wire prs_pkg::prs_acc_s acc_in,
   input wire logic              irq_enter,
   input wire logic [7:0]        irq_page,
   input wire logic              return_from_interrupt,
   // outputs watched
   input wire logic              sfr_out_valid,
   input wire prs_pkg::prs_sfr_s sfr_out,
   input wire logic              ram_valid,
   input wire logic              bit_reject,
   input wire logic              page_miss,
   input wire logic [7:0]        page_select,
   input wire logic [7:0]        page_stack_middle,
   input wire logic [7:0]        page_stack_bottom,
   input wire logic              auto_paging_enable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // helper terms
   logic dir_hit;  // direct access in the paged range
   logic occupied; // page holds registers
   assign dir_hit = acc_in.valid && acc_in.direct && acc_in.addr[7];
   assign occupied = (page_select <= 8'h03) || (page_select == 8'h0f);
   sequence s_push;
      irq_enter && auto_paging_enable;
   endsequence
   sequence s_pop;
      return_from_interrupt && !irq_enter && auto_paging_enable;
   endsequence
   sequence s_quiet;
      !irq_enter && !return_from_interrupt && !acc_in.valid;
   endsequence
   // ==========================================================
   // properties
   a_reset_zero: assert property (disable iff (1'b0) reset |=> page_select == 8'h00 &&
      page_stack_middle == 8'h00 && page_stack_bottom == 8'h00) else $error("stack not cleared");
   a_direct_not_ram: assert property (dir_hit |=> !ram_valid) else $error("paged access sent to ram");
   a_bit_refuse: assert property (dir_hit && acc_in.bit_op && acc_in.addr[2:0] != 3'h0
      |=> bit_reject && !sfr_out_valid) else $error("bit access not refused");
   a_fwd_page: assert property (sfr_out_valid |-> sfr_out.page == $past(page_select))
      else $error("forwarded with wrong page");
   a_empty_page: assert property (dir_hit && !acc_in.bit_op && !occupied
      && !(acc_in.addr inside {8'h84, 8'h85, 8'h86, 8'h8f}) |=> page_miss && !sfr_out_valid)
      else $error("empty page not flagged");
   a_irq_push: assert property (s_push |=> page_select == $past(irq_page)
      && page_stack_middle == $past(page_select) && page_stack_bottom == $past(page_stack_middle))
      else $error("push wrong");
   a_return_pop: assert property (s_pop |=> page_select == $past(page_stack_middle)
      && page_stack_middle == $past(page_stack_bottom) && page_stack_bottom == 8'h00) else $error("pop wrong");
   a_auto_off: assert property (!auto_paging_enable && !acc_in.valid |=> $stable(page_select)
      && $stable(page_stack_middle)) else $error("stack moved while disabled");
   a_sw_store: assert property (dir_hit && acc_in.write && !acc_in.bit_op && acc_in.addr == 8'h85
      && !irq_enter && !return_from_interrupt |=> page_stack_middle == $past(acc_in.wdata)
      && $stable(page_select)) else $error("stack write misbehaved");
   a_stack_still: assert property (s_quiet |=> $stable(page_select)
      && $stable(page_stack_bottom)) else $error("stack moved without event");
endmodule
bind prs_paged_decoder prs_checker u_chk (.*);

// *** testbench/prs_core_model.sv ***
// model of the core: direct accesses and interrupt events
// assumes the bench calls its tasks; drives on the falling edge
`timescale 1ns/1ps
module prs_core_model
(
   // clock
   input wire logic          core_clk,
   // access and interrupt events
   output prs_pkg::prs_acc_s acc_in,
   output logic              irq_enter,
   output logic [7:0]        irq_page,
   output logic              return_from_interrupt
);
   initial
   begin
      acc_in = '0;
      irq_enter = 1'b0;
      irq_page = 8'h00;
      return_from_interrupt = 1'b0;
   end
   // ==========================================================
   // one direct access held for one edge; only documented addresses used
   task automatic acc(input logic w, input logic b, input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      acc_in = '{1'b1, 1'b1, w, b, 3'h1, a, d};
      @(negedge core_clk);
      acc_in = '0;
   endtask
   // interrupt entry (e=1) or return (e=0), one cycle pulse
   task automatic irq(input logic e, input logic [7:0] p);
      @(negedge core_clk);
      irq_enter = e;
      irq_page = p;
      return_from_interrupt = !e;
      @(negedge core_clk);
      irq_enter = 1'b0;
      return_from_interrupt = 1'b0;
      irq_page = ~p; // not sampled now, so no stale page is shown
   endtask
   // entry, optional return and a stack byte write in one cycle
   task automatic race(input logic r, input logic [7:0] a, input logic [7:0] d, input logic [7:0] p);
      @(negedge core_clk);
      acc_in = '{1'b1, 1'b1, 1'b1, 1'b0, 3'h1, a, d};
      irq_enter = 1'b1;
      irq_page = p;
      return_from_interrupt = r;
      @(negedge core_clk);
      acc_in = '0;
      irq_enter = 1'b0;
      return_from_interrupt = 1'b0;
      irq_page = ~p;
   endtask
endmodule

// *** testbench/paged_register_space_ctrl_test.sv ***
// self-checking bench for the paged register decoder
// assumes the core model drives all design inputs except clock and reset, which the bench drives
`timescale 1ns/1ps
module paged_register_space_ctrl_test;
   logic core_clk = 1'b0; // 200 MHz
   logic reset = 1'b1;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   prs_pkg::prs_acc_s acc_in;
   prs_pkg::prs_sfr_s sfr_out;
   logic irq_enter, return_from_interrupt, sfr_out_valid, ram_valid, rd_valid;
   logic bit_reject, page_miss, auto_paging_enable;
   logic [7:0] irq_page, ram_addr, rd_data, page_select, page_stack_middle, page_stack_bottom;
   always #2.5 core_clk = ~core_clk;
   prs_core_model core (.core_clk(core_clk), .acc_in(acc_in), .irq_enter(irq_enter),
      .irq_page(irq_page), .return_from_interrupt(return_from_interrupt));
   prs_paged_decoder DUT (.core_clk(core_clk), .reset(reset), .acc_in(acc_in), .irq_enter(irq_enter),
      .irq_page(irq_page), .return_from_interrupt(return_from_interrupt), .sfr_out_valid(sfr_out_valid),
      .sfr_out(sfr_out), .ram_valid(ram_valid), .ram_addr(ram_addr), .rd_valid(rd_valid),
      .rd_data(rd_data), .bit_reject(bit_reject), .page_miss(page_miss), .page_select(page_select),
      .page_stack_middle(page_stack_middle), .page_stack_bottom(page_stack_bottom),
      .auto_paging_enable(auto_paging_enable));
   // ==========================================================
   // compare and report
   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, exp, got);
      end
   endtask
   task automatic st(input logic [7:0] t, input logic [7:0] m, input logic [7:0] b);
      chk("top", page_select, t);
      chk("mid", page_stack_middle, m);
      chk("bot", page_stack_bottom, b);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard: whole run is well under 400 cycles
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ==========================================================
   // scenarios
   task automatic t_fwd();
      core.acc(1, 0, 8'h84, 8'h01);
      core.acc(0, 0, 8'h90, 8'h00);
      chk("fwd", {7'h0, sfr_out_valid}, 8'h01);
      chk("fpage", sfr_out.page, 8'h01);
      chk("faddr", sfr_out.addr, 8'h90);
      core.acc(1, 0, 8'h91, 8'h5a);
      chk("fwdat", sfr_out.wdata, 8'h5a);
      chk("fwr", {7'h0, sfr_out.write}, 8'h01);
      core.acc(0, 0, 8'h84, 8'h00);
      chk("rd", rd_data, 8'h01);
      chk("rdv", {7'h0, rd_valid}, 8'h01);
      core.acc(0, 0, 8'h7f, 8'h00);
      chk("ram", {7'h0, ram_valid}, 8'h01);
      chk("raddr", ram_addr, 8'h7f);
      core.acc(0, 1, 8'h88, 8'h00);
      chk("bit8", {7'h0, sfr_out_valid}, 8'h01);
      chk("bidx", {5'h0, sfr_out.bit_idx}, 8'h01);
      core.acc(1, 1, 8'h89, 8'h00);
      chk("bit9", {7'h0, bit_reject}, 8'h01);
      chk("bit9f", {7'h0, sfr_out_valid}, 8'h00);
      $display("done t_fwd");
   endtask
   task automatic t_pages();
      logic [7:0] pg[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0f, 8'h05, 8'hff};
      foreach (pg[i])
      begin
         core.acc(1, 0, 8'h84, pg[i]);
         core.acc(0, 0, 8'ha0, 8'h00);
         chk("hit", {7'h0, sfr_out_valid}, {7'h0, i < 5});
         chk("miss", {7'h0, page_miss}, {7'h0, i >= 5});
      end
      $display("done t_pages");
   endtask
   task automatic t_irq();
      core.acc(1, 0, 8'h84, 8'h03);
      core.irq(1, 8'h02);
      st(8'h02, 8'h03, 8'h00);
      core.irq(1, 8'h0f);
      st(8'h0f, 8'h02, 8'h03);
      core.irq(0, 8'h00);
      st(8'h02, 8'h03, 8'h00);
      core.irq(0, 8'h00);
      st(8'h03, 8'h00, 8'h00);
      core.irq(1, 8'h01);
      core.acc(1, 0, 8'h85, 8'h0f);
      st(8'h01, 8'h0f, 8'h00);
      core.irq(0, 8'h00);
      chk("ret", page_select, 8'h0f);
      $display("done t_irq");
   endtask
   task automatic t_off();
      core.acc(1, 0, 8'h8f, 8'h00);
      chk("en", {7'h0, auto_paging_enable}, 8'h00);
      core.irq(1, 8'h02);
      st(8'h0f, 8'h00, 8'h00);
      core.irq(0, 8'h00);
      st(8'h0f, 8'h00, 8'h00);
      core.acc(1, 0, 8'h8f, 8'h01);
      $display("done t_off");
   endtask
   task automatic t_race();
      core.race(1'b1, 8'h85, 8'h44, 8'h02);
      st(8'h02, 8'h0f, 8'h00);
      core.irq(0, 8'h00);
      st(8'h0f, 8'h00, 8'h00);
      $display("done t_race");
   endtask
   task automatic t_reset();
      core.acc(1, 0, 8'h8f, 8'h00);
      core.acc(1, 0, 8'h84, 8'h03);
      core.acc(1, 0, 8'h85, 8'h07);
      core.acc(1, 0, 8'h86, 8'h09);
      @(negedge core_clk);
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      st(8'h00, 8'h00, 8'h00);
      chk("en1", {7'h0, auto_paging_enable}, 8'h01);
      $display("done t_reset");
   endtask
   initial
   begin
      repeat (10) @(negedge core_clk);
      reset = 1'b0;
      st(8'h00, 8'h00, 8'h00);
      chk("en0", {7'h0, auto_paging_enable}, 8'h01);
      t_fwd();
      t_pages();
      t_irq();
      t_off();
      t_race();
      t_reset();
      tally_and_finish();
   end
endmodule
